//--- verilog/cic_pkg.sv
package cic_pkg;

    // ********************************************************************
    // Register map (index of one byte register)
    // ********************************************************************
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_PFLAG1  = 4'h1;
    localparam logic [3:0] ADDR_PFLAG2  = 4'h2;
    localparam logic [3:0] ADDR_PFLAG3  = 4'h3;
    localparam logic [3:0] ADDR_PEN1    = 4'h4;
    localparam logic [3:0] ADDR_PEN2    = 4'h5;
    localparam logic [3:0] ADDR_PEN3    = 4'h6;
    localparam logic [3:0] ADDR_OPTION  = 4'h7;
    localparam logic [3:0] ADDR_IRQ_ST  = 4'h8;
    localparam logic [3:0] ADDR_IRQ_MSK = 4'h9;

    // ********************************************************************
    // Control and option register field positions
    // ********************************************************************
    localparam int BIT_GIE    = 7;
    localparam int BIT_PERIPHERAL_GROUP_IRQ_ENABLE   = 6;
    localparam int BIT_TMR_IE = 5;
    localparam int BIT_EXT_IE = 4;
    localparam int BIT_IOC_IE = 3;
    localparam int BIT_TMR_IF = 2;
    localparam int BIT_EXT_IF = 1;
    localparam int BIT_IOC_IF = 0;
    localparam int BIT_EDGE   = 6;

    // ********************************************************************
    // Widths, reset values, timing
    // ********************************************************************
    localparam int          NPER     = 3;
    localparam int          CTX_W    = 32;
    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [7:0]  OPT_RST  = 8'h40;
    localparam logic [14:0] VECTOR   = 15'h0004;
    localparam logic [1:0]  Q1       = 2'h0;
    localparam logic [1:0]  Q4       = 2'h3;
    localparam int          CLK_MHZ  = 20;
    localparam int          QPH_NS   = 50;
    localparam int          QPH_CYC  = (QPH_NS * CLK_MHZ + 999) / 1000;
    localparam logic [3:0]  IRQ_EXT  = 4'h1;
    localparam logic [3:0]  IRQ_TAKE = 4'h2;
    localparam logic [3:0]  IRQ_WAKE = 4'h4;
    localparam logic [3:0]  IRQ_RET  = 4'h8;

    // Sequencer states, Gray along the acceptance path
    typedef enum logic [2:0] {
        CIC_IDLE  = 3'h0,
        CIC_FLUSH = 3'h1,
        CIC_PUSH  = 3'h3,
        CIC_VECT  = 3'h2,
        CIC_ISR   = 3'h6
    } cic_state_type;

endpackage : cic_pkg

//--- verilog/cic_sync.sv
`timescale 1ns/1ps
// Three flop synchroniser with agreement filter on the last two stages
module cic_sync (
    input  wire logic i_clk_sys,
    input  wire logic i_srst,
    input  wire logic i_async,
    output logic      o_level
);
    logic meta;
    logic s2;
    logic s3;

    // ********************************************************************
    // Chain; first stage read only by second
    // ********************************************************************
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            meta    <= 1'b0;
            s2      <= 1'b0;
            s3      <= 1'b0;
            o_level <= 1'b0;
        end else begin
            meta <= i_async;
            s2   <= meta;
            s3   <= s2;
            if (s2 == s3) begin
                o_level <= s3; // Change counts once stages agree
            end
        end
    end
endmodule : cic_sync

//--- verilog/cic_ctx_store.sv
`timescale 1ns/1ps
// Shadow copy of the critical core context, registered read
module cic_ctx_store (
    input  wire logic                      i_clk_sys,
    input  wire logic                      i_srst,
    input  wire logic                      i_save,
    input  wire logic [cic_pkg::CTX_W-1:0] i_ctx,
    output logic      [cic_pkg::CTX_W-1:0] o_ctx
);
    logic [cic_pkg::CTX_W-1:0] shadow;

    // ********************************************************************
    // Store and registered read
    // ********************************************************************
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            shadow <= '0;
            o_ctx  <= '0;
        end else begin
            if (i_save) begin
                shadow <= i_ctx;
            end
            o_ctx <= i_save ? i_ctx : shadow;
        end
    end
endmodule : cic_ctx_store

//--- verilog/cic_top.sv
`timescale 1ns/1ps
// Function
// - any reset clears every enable so nothing vectors
// - vectoring needs global and own enable, peripherals also group enable
// - flags set on events whatever the enables
// - flags live in control register and three peripheral flag registers
// - accept flushes, drops global enable, pushes pc, saves context, vectors
// - with global enable clear flags set but no redirect; serviced later
// - flag left set re-enters after return; software clears flags, change flag follows its source
// - return pops address, restores context, sets global enable
// - synchronous event to vector in three or four instruction cycles
// - asynchronous event to vector in three to five cycles
// - latency independent of one or two cycle instruction
// - pin flag settable in Q4 to Q1, sampled every Q1
// - enabled sources wake the core from sleep
// - pin edge select: set means rising, clear means falling
// - after wake next instruction runs first; branch only if global enable
module cic_top (
    input  wire logic        i_clk_sys,
    input  wire logic        i_srst,
    input  wire logic [3:0]  i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [7:0]  o_rdata,
    input  wire logic        i_ext_pin,
    input  wire logic        i_tmr_evt,
    input  wire logic        i_ioc_any,
    input  wire logic [23:0] i_per_evt,
    input  wire logic [14:0] i_pc,
    input  wire logic [31:0] i_ctx,
    input  wire logic        i_return_from_isr_instr,
    input  wire logic        i_sleeping,
    input  wire logic        i_wake_instr_done,
    output logic             o_wake,
    output logic             o_flush,
    output logic             o_push,
    output logic      [14:0] o_push_pc,
    output logic             o_load_pc,
    output logic      [14:0] o_vector,
    output logic             o_restore,
    output logic      [31:0] o_ctx,
    output logic      [1:0]  o_qphase,
    output logic             o_irq_req,
    output logic             o_irq
);
    logic [7:0]                irq_control_reg;
    logic [7:0]                peripheral_flag_reg   [cic_pkg::NPER];
    logic [7:0]                peripheral_enable_reg [cic_pkg::NPER];
    logic [7:0]                option_reg;
    logic [3:0]                irq_status;
    logic [3:0]                irq_mask;
    logic [1:0]                qphase;
    logic [1:0]                qdiv;
    logic                      q_tick;
    logic                      pin_sync;
    logic                      pin_prev;
    logic                      ext_edge;
    logic                      per_pend;
    logic                      core_pend;
    logic                      any_pend;
    logic                      req_s;
    logic                      wake_hold;
    logic                      accept;
    logic                      take_evt;
    logic [cic_pkg::CTX_W-1:0] ctx_rd;
    cic_pkg::cic_state_type    state;
    cic_pkg::cic_state_type    next_state;

    // Flag-and-enable product of one peripheral register
    function automatic logic per_hit(input logic [7:0] f, input logic [7:0] e);
        per_hit = |(f & e);
    endfunction : per_hit

    function automatic logic wr_hit(input logic w, input logic [3:0] a,
                                    input logic [3:0] t);
        wr_hit = w && (a == t);
    endfunction : wr_hit

    // ********************************************************************
    // Phase generator: four Q phases per instruction cycle
    // ********************************************************************
    assign q_tick = (qdiv == 2'(cic_pkg::QPH_CYC - 1));

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            qdiv   <= '0;
            qphase <= cic_pkg::Q1;
        end else begin
            qdiv <= q_tick ? 2'h0 : qdiv + 2'h1;
            if (q_tick) begin
                qphase <= qphase + 2'h1;
            end
        end
    end

    // ********************************************************************
    // External pin: filtered, edge chosen by select bit
    // ********************************************************************
    cic_sync u_pin (
        .i_clk_sys (i_clk_sys),
        .i_srst    (i_srst),
        .i_async   (i_ext_pin),
        .o_level   (pin_sync)
    );

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            pin_prev <= 1'b0;
        end else begin
            pin_prev <= pin_sync;
        end
    end

    // Edge select set is rising edge
    assign ext_edge = option_reg[cic_pkg::BIT_EDGE]
                      ? (pin_sync & ~pin_prev)
                      : (~pin_sync & pin_prev);

    // ********************************************************************
    // Control register: enables writable, flags set beat software clear
    // ********************************************************************
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            irq_control_reg <= cic_pkg::RST_BYTE;
        end else begin
            if (wr_hit(i_wr, i_addr, cic_pkg::ADDR_CONTROL)) begin
                irq_control_reg[7:1] <= i_wdata[7:1];
            end
            if (take_evt) begin
                irq_control_reg[cic_pkg::BIT_GIE] <= 1'b0;
            end else if (state == cic_pkg::CIC_ISR && i_return_from_isr_instr) begin
                irq_control_reg[cic_pkg::BIT_GIE] <= 1'b1;
            end
            // Flags set independent of any enable
            if (ext_edge) begin
                irq_control_reg[cic_pkg::BIT_EXT_IF] <= 1'b1;
            end
            if (i_tmr_evt) begin
                irq_control_reg[cic_pkg::BIT_TMR_IF] <= 1'b1;
            end
            // Change flag mirrors the source, read only
            irq_control_reg[cic_pkg::BIT_IOC_IF] <= i_ioc_any;
        end
    end

    // ********************************************************************
    // Peripheral flag and enable registers
    // ********************************************************************
    for (genvar g = 0; g < cic_pkg::NPER; g++) begin : g_per
        always_ff @(posedge i_clk_sys) begin
            if (i_srst) begin
                peripheral_flag_reg[g]   <= cic_pkg::RST_BYTE;
                peripheral_enable_reg[g] <= cic_pkg::RST_BYTE;
            end else begin
                // Set wins over the write that clears
                if (wr_hit(i_wr, i_addr, 4'(cic_pkg::ADDR_PFLAG1 + g))) begin
                    peripheral_flag_reg[g] <= i_wdata
                        | i_per_evt[g*8 +: 8];
                end else begin
                    peripheral_flag_reg[g] <= peripheral_flag_reg[g]
                        | i_per_evt[g*8 +: 8];
                end
                if (wr_hit(i_wr, i_addr, 4'(cic_pkg::ADDR_PEN1 + g))) begin
                    peripheral_enable_reg[g] <= i_wdata;
                end
            end
        end
    end

    // Edge select register
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            option_reg <= cic_pkg::OPT_RST;
        end else if (wr_hit(i_wr, i_addr, cic_pkg::ADDR_OPTION)) begin
            option_reg <= i_wdata;
        end
    end

    // ********************************************************************
    // Pending request: OR of enabled flags with group qualifiers
    // ********************************************************************
    always_comb begin
        per_pend = 1'b0;
        for (int k = 0; k < cic_pkg::NPER; k++) begin
            per_pend = per_pend | per_hit(peripheral_flag_reg[k],
                                          peripheral_enable_reg[k]);
        end
        core_pend = |(irq_control_reg[5:3] & irq_control_reg[2:0]);
        any_pend = core_pend | (per_pend & irq_control_reg[cic_pkg::BIT_PERIPHERAL_GROUP_IRQ_ENABLE]);
    end

    // Sampled once per instruction cycle at Q1, so latency depends on the event phase, not the instruction
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            req_s <= 1'b0;
        end else if (q_tick && qphase == cic_pkg::Q4) begin
            req_s <= any_pend & irq_control_reg[cic_pkg::BIT_GIE];
        end
    end

    // ********************************************************************
    // Sleep wake: next instruction completes before any branch
    // ********************************************************************
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_wake    <= 1'b0;
            wake_hold <= 1'b0;
        end else begin
            o_wake <= i_sleeping & any_pend;
            if (i_sleeping & any_pend) begin
                wake_hold <= 1'b1;
            end else if (i_wake_instr_done) begin
                wake_hold <= 1'b0;
            end
        end
    end

    // Accept on a Q1 boundary; GLOBAL_IRQ_ENABLE gate keeps disabled flags pending
    assign accept = req_s && !wake_hold && q_tick && qphase == cic_pkg::Q1
                    && irq_control_reg[cic_pkg::BIT_GIE];
    assign take_evt = (state == cic_pkg::CIC_IDLE) && accept;

    // ********************************************************************
    // Entry sequencer; flush holds to the Q4 boundary, push and vector one clock each
    // ********************************************************************
    always_comb begin
        next_state = state;
        unique case (state)
            cic_pkg::CIC_IDLE:  if (accept) next_state = cic_pkg::CIC_FLUSH;
            cic_pkg::CIC_FLUSH: if (q_tick && qphase == cic_pkg::Q4)
                                    next_state = cic_pkg::CIC_PUSH;
            cic_pkg::CIC_PUSH:  next_state = cic_pkg::CIC_VECT;
            cic_pkg::CIC_VECT:  next_state = cic_pkg::CIC_ISR;
            cic_pkg::CIC_ISR:   if (i_return_from_isr_instr) next_state = cic_pkg::CIC_IDLE;
            default:            next_state = cic_pkg::CIC_IDLE;
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            state <= cic_pkg::CIC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Core strobes; sequence length does not look at the instruction
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_flush   <= 1'b0;
            o_push    <= 1'b0;
            o_push_pc <= '0;
            o_load_pc <= 1'b0;
            o_vector  <= '0;
            o_restore <= 1'b0;
        end else begin
            o_flush   <= take_evt;
            o_push    <= state == cic_pkg::CIC_PUSH;
            o_push_pc <= (state == cic_pkg::CIC_FLUSH) ? i_pc : o_push_pc;
            o_load_pc <= state == cic_pkg::CIC_VECT;
            o_vector  <= cic_pkg::VECTOR;
            o_restore <= state == cic_pkg::CIC_ISR && i_return_from_isr_instr;
        end
    end

    cic_ctx_store u_ctx (
        .i_clk_sys (i_clk_sys),
        .i_srst    (i_srst),
        .i_save    (take_evt),
        .i_ctx     (i_ctx),
        .o_ctx     (ctx_rd)
    );

    // ********************************************************************
    // Status interrupt bits, write one to clear, set wins
    // ********************************************************************
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            irq_status <= '0;
            irq_mask   <= '0;
        end else begin
            irq_status <= (wr_hit(i_wr, i_addr, cic_pkg::ADDR_IRQ_ST)
                           ? irq_status & ~i_wdata[3:0] : irq_status)
                          | (ext_edge ? cic_pkg::IRQ_EXT : 4'h0)
                          | (take_evt ? cic_pkg::IRQ_TAKE : 4'h0)
                          | ((i_sleeping & any_pend) ? cic_pkg::IRQ_WAKE : 4'h0)
                          | (o_restore ? cic_pkg::IRQ_RET : 4'h0);
            if (wr_hit(i_wr, i_addr, cic_pkg::ADDR_IRQ_MSK)) begin
                irq_mask <= i_wdata[3:0];
            end
        end
    end

    // ********************************************************************
    // Read port and registered outputs
    // ********************************************************************
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_rdata   <= '0;
            o_irq     <= 1'b0;
            o_irq_req <= 1'b0;
            o_ctx     <= '0;
            o_qphase  <= cic_pkg::Q1;
        end else begin
            o_irq     <= |(irq_status & irq_mask);
            o_irq_req <= req_s;
            o_ctx     <= ctx_rd;
            o_qphase  <= qphase;
            o_rdata   <= '0;
            if (i_rd) begin
                unique case (i_addr)
                    cic_pkg::ADDR_CONTROL: o_rdata <= irq_control_reg;
                    cic_pkg::ADDR_PFLAG1:  o_rdata <= peripheral_flag_reg[0];
                    cic_pkg::ADDR_PFLAG2:  o_rdata <= peripheral_flag_reg[1];
                    cic_pkg::ADDR_PFLAG3:  o_rdata <= peripheral_flag_reg[2];
                    cic_pkg::ADDR_PEN1:    o_rdata <= peripheral_enable_reg[0];
                    cic_pkg::ADDR_PEN2:    o_rdata <= peripheral_enable_reg[1];
                    cic_pkg::ADDR_PEN3:    o_rdata <= peripheral_enable_reg[2];
                    cic_pkg::ADDR_OPTION:  o_rdata <= option_reg;
                    cic_pkg::ADDR_IRQ_ST:  o_rdata <= {4'h0, irq_status};
                    cic_pkg::ADDR_IRQ_MSK: o_rdata <= {4'h0, irq_mask};
                    default:               o_rdata <= '0;
                endcase
            end
        end
    end

    // ********************************************************************
    // Checks
    // ********************************************************************
    a_reset_gie_off: assert property (@(posedge i_clk_sys)
        i_srst |=> !irq_control_reg[cic_pkg::BIT_GIE]) else $error("gie on");
    a_take_clears_gie: assert property (@(posedge i_clk_sys)
        disable iff (i_srst) take_evt |=> !irq_control_reg[cic_pkg::BIT_GIE])
        else $error("gie kept");
    a_no_gie_no_take: assert property (@(posedge i_clk_sys)
        disable iff (i_srst) !irq_control_reg[cic_pkg::BIT_GIE] |-> !take_evt)
        else $error("took with gie off");
    a_flag_sets: assert property (@(posedge i_clk_sys)
        disable iff (i_srst) i_tmr_evt |=> irq_control_reg[cic_pkg::BIT_TMR_IF])
        else $error("flag lost");
    a_flag_sticky: assert property (@(posedge i_clk_sys)
        disable iff (i_srst) irq_control_reg[cic_pkg::BIT_EXT_IF]
        && !wr_hit(i_wr, i_addr, cic_pkg::ADDR_CONTROL)
        |=> irq_control_reg[cic_pkg::BIT_EXT_IF]) else $error("flag dropped");
    a_ret_sets_gie: assert property (@(posedge i_clk_sys)
        disable iff (i_srst) o_restore |-> irq_control_reg[cic_pkg::BIT_GIE])
        else $error("gie not set");
    a_entry_order: assert property (@(posedge i_clk_sys)
        disable iff (i_srst) $rose(o_push) |=> o_load_pc) else $error("order");
    a_vector_value: assert property (@(posedge i_clk_sys)
        disable iff (i_srst) o_load_pc |-> o_vector == cic_pkg::VECTOR)
        else $error("bad vector");
    a_flush_latency: assert property (@(posedge i_clk_sys)
        disable iff (i_srst) take_evt |-> ##5 $rose(o_push))
        else $error("entry late");
endmodule : cic_top

//--- tb/cic_core_model.sv
`timescale 1ns/1ps
// ********************************************************************
// Core side: holds pc and context, returns after a short routine
// ********************************************************************
module cic_core_model (
    input  wire logic        i_clk_sys,
    input  wire logic        i_load_pc,
    output logic      [14:0] o_pc,
    output logic      [31:0] o_ctx,
    output logic             o_return_from_isr_instr
);
    int cnt = 0;

    // Known values at time zero, no unknowns reach the controller
    initial begin
        o_pc     = 15'h0123;
        o_ctx    = 32'h5a5a_c3c3;
        o_return_from_isr_instr = 1'b0;
    end

    // Routine edits context so a lost shadow copy shows
    always @(posedge i_clk_sys) begin
        o_return_from_isr_instr <= 1'b0;
        if (i_load_pc) begin
            cnt   <= 6;
            o_pc  <= 15'h0004;
            o_ctx <= ~o_ctx;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
            if (cnt == 1) begin
                o_return_from_isr_instr <= 1'b1;
            end
        end
    end
endmodule : cic_core_model

//--- tb/tb.sv
`timescale 1ns/1ps
// ********************************************************************
// Bench: clock, bus tasks, reference model and checks
// ********************************************************************
module tb;
    logic        clk = 0, rst = 1, wr = 0, rd = 0, pin = 0, tmr = 0;
    logic        slp = 0, wdone = 0, return_from_isr_instr, flush, push, load, rest;
    logic        wake, irq, req, ioc = 0;
    logic [1:0]  qph;
    logic [3:0]  addr = 0;
    logic [7:0]  wd = 0, rdat;
    logic [23:0] per = 0;
    logic [14:0] pc, ppc, vec;
    logic [31:0] ctx, octx;
    logic [15:0] rnd = 16'd56418;
    logic [14:0] pc_q[$];
    logic [31:0] ctx_q[$];
    int          num_errors = 0, checks_done = 0, n_acc = 0, lat, na, idx;

    cic_top uut (.i_clk_sys(clk), .i_srst(rst), .i_addr(addr), .i_wdata(wd),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdat), .i_ext_pin(pin),
        .i_tmr_evt(tmr), .i_ioc_any(ioc), .i_per_evt(per), .i_pc(pc),
        .i_ctx(ctx), .i_return_from_isr_instr(return_from_isr_instr), .i_sleeping(slp),
        .i_wake_instr_done(wdone), .o_wake(wake), .o_flush(flush),
        .o_push(push), .o_push_pc(ppc), .o_load_pc(load), .o_vector(vec),
        .o_restore(rest), .o_ctx(octx), .o_qphase(qph), .o_irq_req(req),
        .o_irq(irq));
    cic_core_model core (.i_clk_sys(clk), .i_load_pc(load), .o_pc(pc),
        .o_ctx(ctx), .o_return_from_isr_instr(return_from_isr_instr));

    // 20 MHz clock
    initial begin
        forever #25 clk = ~clk;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task automatic check(input string nm, input logic [31:0] s, e);
        checks_done++;
        if (s !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask : check

    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr   <= 1'b1;
        addr <= a;
        wd   <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wreg

    // Read data stands only in the cycle after the strobe
    task automatic rreg(input logic [3:0] a, input logic [7:0] e, string nm);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 check(nm, rdat, e);
    endtask : rreg

    task automatic pulse(input logic [24:0] m);
        @(posedge clk);
        {tmr, per} <= m;
        @(posedge clk);
        {tmr, per} <= 25'h0;
    endtask : pulse

    // Bounded wait for the vector load, cycles counted in lat
    task automatic wait_load(input int mx);
        lat = 0;
        do begin
            @(posedge clk);
            #1 lat++;
        end while (load !== 1'b1 && lat < mx);
    endtask : wait_load

    task automatic final_report;
        if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : final_report

    // Reference: pc and context taken at acceptance, compared on use
    always @(posedge clk) begin
        if (flush === 1'b1) begin
            n_acc++;
            check("qphase", qph, cic_pkg::Q1);
            pc_q.push_back(pc);
            ctx_q.push_back(ctx);
        end
        if (push === 1'b1) check("push_pc", ppc, pc_q.pop_front());
        if (load === 1'b1) check("vector", vec, 15'h0004);
        if (rest === 1'b1) check("ctx", octx, ctx_q.pop_front());
    end

    // Watchdog well beyond the expected run
    initial begin
        tick(20000);
        num_errors++;
        final_report;
    end

    initial begin
        tick(2);
        rst <= 1'b0;
        rreg(cic_pkg::ADDR_CONTROL, 8'h00, "ctl_rst");
        rreg(cic_pkg::ADDR_OPTION, 8'h40, "opt_rst");
        // Flag sets with all enables off, nothing vectors
        pulse(25'h1000000);
        tick(30);
        rreg(cic_pkg::ADDR_CONTROL, 8'h04, "tmr_flag");
        check("acc_off", n_acc, 0);
        // Late enable services the pending flag, then re-enters
        wreg(cic_pkg::ADDR_CONTROL, 8'ha4);
        wait_load(30);
        check("serviced", load, 1);
        wait_load(60);
        check("reenter", load, 1);
        wreg(cic_pkg::ADDR_CONTROL, 8'h20);
        tick(30);
        na = n_acc;
        tick(30);
        #1 check("quiet", n_acc, na);
        // Event with global enable already set
        wreg(cic_pkg::ADDR_CONTROL, 8'ha0);
        pulse(25'h1000000);
        wait_load(30);
        check("sync_lat", lat <= 16, 1);
        wreg(cic_pkg::ADDR_CONTROL, 8'h20);
        tick(20);
        // Random peripheral source, group enable off then on
        rnd = lfsr(rnd);
        idx = rnd % 24;
        wreg(4'(cic_pkg::ADDR_PEN1 + idx / 8), 8'hff);
        wreg(cic_pkg::ADDR_CONTROL, 8'h80);
        na = n_acc;
        pulse(25'h1 << idx);
        tick(30);
        #1 check("no_group", n_acc, na);
        check("req_off", req, 0);
        rreg(4'(cic_pkg::ADDR_PFLAG1 + idx / 8), 8'(1 << (idx % 8)),
             "pf");
        wreg(cic_pkg::ADDR_CONTROL, 8'hc0);
        wait_load(30);
        check("group_on", load, 1);
        wreg(4'(cic_pkg::ADDR_PFLAG1 + idx / 8), 8'h00);
        tick(30);
        // Pin edges: falling then rising selected
        for (int e = 0; e < 2; e++) begin
            pin <= e[0];
            tick(8);
            wreg(cic_pkg::ADDR_OPTION, e[0] ? 8'h40 : 8'h00);
            wreg(cic_pkg::ADDR_CONTROL, 8'h00);
            pin <= !e[0];
            tick(8);
            rreg(cic_pkg::ADDR_CONTROL, 8'h00, "wrong_edge");
            pin <= e[0];
            tick(8);
            rreg(cic_pkg::ADDR_CONTROL, 8'h02, "right_edge");
        end
        // Sleep: enabled flag wakes, no branch with global enable clear
        na = n_acc;
        wreg(cic_pkg::ADDR_CONTROL, 8'h20);
        pulse(25'h1000000);
        slp <= 1'b1;
        tick(4);
        #1 check("wake", wake, 1);
        slp <= 1'b0;
        tick(1);
        wdone <= 1'b1;
        tick(1);
        wdone <= 1'b0;
        tick(20);
        #1 check("no_branch", n_acc, na);
        // Status, mask and interrupt line
        wreg(cic_pkg::ADDR_IRQ_MSK, 8'h00);
        tick(3);
        #1 check("irq_masked", irq, 0);
        wreg(cic_pkg::ADDR_IRQ_MSK, 8'h02);
        tick(3);
        #1 check("irq_on", irq, 1);
        wreg(cic_pkg::ADDR_IRQ_ST, 8'h0f);
        tick(3);
        #1 check("irq_clr", irq, 0);
        // Change source mirrored into its flag, timer enable still set
        tick(1);
        ioc <= 1'b1;
        rreg(cic_pkg::ADDR_CONTROL, 8'h25, "ioc_flag");
        rreg(4'hf, 8'h00, "unmapped");
        final_report;
    end
endmodule : tb
